// file: hdl/iopc_chain.sv
// Functional notes
// - Code 04 highest, priority falls toward 77.
// - Request needs flag, enable, control, priority in.
// - Requesting card drops priority to lower cards.
// - Clear flag passes priority unchanged downward.
// - Non-requesting card never blocks the chain.
// - Cleared control blocks interrupt, flag stays testable.
// - All nine instructions suppress the interrupt that cycle and the next.
// - Set/clear control starts or stops device.
// - Set/clear flag instructions drive flag.
// - Skip tests report addressed channel flag.
// - Output instruction writes accumulator to buffer.
// - Power-fail flag follows power, skip reports failure.
// - Set control with modifier also clears flag.
// - Grant supplies winning select code as address.
// - Code 00 holds interrupt system enable, skippable.
`timescale 1ns/1ps
`include "iopc_map.svh"

module iopc_chain #(
  parameter int NCH = `IOPC_NCH
) (
  input  wire logic                      clk_i,        // 125 MHz clock
  input  wire logic                      rst_i,        // Synchronous reset
  input  wire logic                      wb_cyc_i,     // Wishbone cycle
  input  wire logic                      wb_stb_i,     // Wishbone strobe
  input  wire logic                      wb_we_i,      // Wishbone write
  input  wire logic [3:0]                wb_adr_i,     // Byte address
  input  wire logic [3:0]                wb_sel_i,     // Byte lanes
  input  wire logic [31:0]               wb_dat_i,     // Write data
  output logic      [31:0]               wb_dat_o,     // Read data
  output logic                           wb_ack_o,     // Acknowledge
  input  wire logic                      pwr_ok_i,     // Power good pin
  input  wire logic [NCH-1:0]            dev_done_i,   // Device done pins
  input  wire logic [NCH-1:0][15:0]      dev_data_i,   // Device input data
  output logic      [NCH-1:0]            dev_start_o,  // Device start
  output logic      [NCH-1:0][15:0]      dev_buf_o,    // Card data buffers
  input  wire logic                      int_ack_i,    // Processor takes irq
  output logic                           irq_o,        // Interrupt request
  output logic      [5:0]                irq_sra_o     // Service request address
);

  if (NCH < 1 || NCH > `IOPC_NCH) begin : g_bad_nch
    $error("NCH must lie between 1 and 56");
  end

  ////////////////////////////////////////////////////////////////////////////
  logic                 ack_r;
  logic                 io_cycle;
  logic                 exec;
  logic                 exec_d_r;
  iopc_pkg::iopc_cmd_t  cmd;
  logic [5:0]           ch_idx;
  logic                 on_ch;
  logic                 on_ien;
  logic                 on_pf;
  logic [NCH-1:0]       sel_v;
  logic                 x_setc;
  logic                 x_clrc;
  logic                 x_setf;
  logic                 x_clrf;
  logic                 x_sfs;
  logic                 x_sfc;
  logic                 x_lia;
  logic                 x_mia;
  logic                 x_ota;

  // The whole bus access to the command word is one processor I/O cycle.
  assign io_cycle = wb_cyc_i & wb_stb_i & (wb_adr_i == `IOPC_ADR_CMD);
  assign exec     = io_cycle & wb_we_i & ack_r & (&wb_sel_i[1:0]);
  assign cmd      = iopc_pkg::iopc_cmd_t'(wb_dat_i[`IOPC_CMD_W-1:0]);
  assign ch_idx   = cmd.sc - `IOPC_SC_FIRST;
  assign on_ch    = (cmd.sc >= `IOPC_SC_FIRST) && (int'(ch_idx) < NCH);
  assign on_ien   = cmd.sc == `IOPC_SC_IEN;
  assign on_pf    = cmd.sc == `IOPC_SC_PF;
  assign x_setc   = exec & (cmd.op == iopc_pkg::op_set_control);
  assign x_clrc   = exec & (cmd.op == iopc_pkg::op_clear_control);
  assign x_setf   = exec & (cmd.op == iopc_pkg::op_set_flag);
  assign x_clrf   = exec & (cmd.op == iopc_pkg::op_clear_flag);
  assign x_sfs    = exec & (cmd.op == iopc_pkg::op_skip_set);
  assign x_sfc    = exec & (cmd.op == iopc_pkg::op_skip_clear);
  assign x_lia    = exec & (cmd.op == iopc_pkg::op_load_input);
  assign x_mia    = exec & (cmd.op == iopc_pkg::op_merge_input);
  assign x_ota    = exec & (cmd.op == iopc_pkg::op_output_acc);

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      sel_v[i] = on_ch && (int'(ch_idx) == i);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r    <= 1'b0;
      exec_d_r <= 1'b0;
    end else begin
      ack_r    <= wb_cyc_i & wb_stb_i & ~ack_r;
      exec_d_r <= exec;
    end
  end

  assign wb_ack_o = ack_r;

  ////////////////////////////////////////////////////////////////////////////
  // Pins pass three flops; a level counts once the second and third agree.
  logic [NCH:0] s1_r;
  logic [NCH:0] s2_r;
  logic [NCH:0] s3_r;
  logic [NCH:0] lvl_r;
  logic [NCH:0] lvl_nxt;
  logic [NCH-1:0] rise;
  logic           pf_flag;

  assign lvl_nxt = (s2_r & s3_r) | (lvl_r & (s2_r | s3_r));
  assign rise    = lvl_nxt[NCH-1:0] & ~lvl_r[NCH-1:0];
  assign pf_flag = lvl_r[NCH];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r  <= '0;
      s2_r  <= '0;
      s3_r  <= '0;
      lvl_r <= '0;
    end else begin
      s1_r  <= {pwr_ok_i, dev_done_i};
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [NCH-1:0] ctl_r;
  logic [NCH-1:0] flag_r;
  logic [NCH-1:0] flag_nxt;
  logic           ien_r;
  logic           arm_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_r <= {NCH{`IOPC_CTL_RST}};
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (x_setc && sel_v[i]) begin
          ctl_r[i] <= 1'b1;
        end else if (x_clrc && (sel_v[i] || on_ien)) begin
          ctl_r[i] <= 1'b0;
        end
      end
    end
  end

  assign dev_start_o = ctl_r;

  // A done edge in the same cycle as a clearing instruction wins.
  assign flag_nxt = (flag_r & ~(sel_v & {NCH{x_clrf | (x_setc & cmd.clr_flag)}}))
                  | (sel_v & {NCH{x_setf}})
                  | rise;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_r <= {NCH{`IOPC_FLG_RST}};
    end else begin
      flag_r <= flag_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ien_r <= `IOPC_IEN_RST;
    end else if (on_ien && x_setf) begin
      ien_r <= 1'b1;
    end else if (on_ien && x_clrf) begin
      ien_r <= 1'b0;
    end
  end

  // After its own grant the power-fail source stays quiet until re-armed.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      arm_r <= `IOPC_ARM_RST;
    end else if (on_pf && (x_setc || x_clrc)) begin
      arm_r <= 1'b1;
    end else if (int_ack_i && irq_o && (irq_sra_o == `IOPC_SC_PF)) begin
      arm_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic           req_pf;
  logic [NCH-1:0] req;
  logic [NCH:0]   prio;
  logic [5:0]     sra_nxt;
  logic           pend_r;
  logic [5:0]     sra_r;
  logic [5:0]     cir_r;

  // Power fail sits at the head of the chain, channels follow upward.
  assign req_pf = ~pf_flag & arm_r & ien_r;

  always_comb begin
    prio[0] = ~req_pf;
    sra_nxt = req_pf ? `IOPC_SC_PF : 6'h00;
    for (int i = 0; i < NCH; i++) begin
      req[i]    = flag_r[i] & ien_r & ctl_r[i] & prio[i];
      prio[i+1] = prio[i] & ~req[i];
      if (req[i]) begin
        sra_nxt = 6'(i) + `IOPC_SC_FIRST;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_r <= 1'b0;
      sra_r  <= 6'h00;
    end else begin
      pend_r <= req_pf | (|req);
      sra_r  <= sra_nxt;
    end
  end

  // The cycle after an instruction is also masked, since the pending
  // flop still reflects the state before it.
  assign irq_o     = pend_r & ~io_cycle & ~exec_d_r;
  assign irq_sra_o = sra_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cir_r <= 6'h00;
    end else if (int_ack_i && irq_o) begin
      cir_r <= sra_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [NCH-1:0][15:0] buf_r;
  logic [15:0]          acc_r;
  logic [15:0]          cur_buf;
  logic                 skip_r;

  assign cur_buf   = on_ch ? buf_r[ch_idx] : 16'h0000;
  assign dev_buf_o = buf_r;

  // Software output wins over device input landing in the same cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      buf_r <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (x_ota && sel_v[i]) begin
          buf_r[i] <= acc_r;
        end else if (rise[i]) begin
          buf_r[i] <= dev_data_i[i];
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_r <= 16'h0000;
    end else if (x_lia && on_ch) begin
      acc_r <= cur_buf;
    end else if (x_mia && on_ch) begin
      acc_r <= acc_r | cur_buf;
    end else if (x_lia && on_ien) begin
      acc_r <= 16'h0000;
    end else if (x_lia && on_pf) begin
      acc_r <= {10'h000, cir_r};
    end else if (x_mia && on_pf) begin
      acc_r <= acc_r | {10'h000, cir_r};
    end else if (wb_cyc_i && wb_stb_i && wb_we_i && ack_r
                 && wb_adr_i == `IOPC_ADR_ACC) begin
      if (wb_sel_i[0]) acc_r[7:0] <= wb_dat_i[7:0];
      if (wb_sel_i[1]) acc_r[15:8] <= wb_dat_i[15:8];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      skip_r <= 1'b0;
    end else if (exec) begin
      skip_r <= (x_sfs & on_ch & |(flag_r & sel_v))
              | (x_sfc & on_ch & ~|(flag_r & sel_v))
              | (x_sfs & on_ien & ien_r)
              | (x_sfc & on_ien & ~ien_r)
              | (x_sfc & on_pf & ~pf_flag);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  iopc_pkg::iopc_stat_t stat;
  logic [31:0]          dat_r;

  assign stat = '{cir: cir_r, sra: sra_r, irq: irq_o, pf_flag: pf_flag,
                  interrupt_system_on: ien_r, skip: skip_r};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_r <= 32'h0000_0000;
    end else if (wb_cyc_i && wb_stb_i && !ack_r) begin
      unique case (wb_adr_i)
        `IOPC_ADR_CMD:  dat_r <= {31'h0000_0000, skip_r};
        `IOPC_ADR_ACC:  dat_r <= {16'h0000, acc_r};
        `IOPC_ADR_STAT: dat_r <= {16'h0000, stat};
        default:        dat_r <= 32'h0000_0000;
      endcase
    end
  end

  assign wb_dat_o = dat_r;

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  one_winner_a: assert property ($onehot0({req, req_pf}))
    else $error("more than one channel requesting");
  ack_hold_a: assert property (io_cycle |-> !irq_o)
    else $error("interrupt offered during an I/O instruction");
  ien_skip_a: assert property (x_sfs && on_ien |=> skip_r == $past(ien_r))
    else $error("skip on code 00 does not show enable");
  chan_skip_a: assert property (x_sfc && on_ch |=> skip_r != $past(flag_r[ch_idx]))
    else $error("skip-if-clear mismatches flag");
  out_buf_a: assert property (x_ota && on_ch |=> buf_r[$past(ch_idx)] == $past(acc_r))
    else $error("output did not reach buffer");
  load_acc_a: assert property (x_lia && on_ch |=> acc_r == $past(cur_buf))
    else $error("load input wrong");
  pf_level_a: assert property (s2_r[NCH] && s3_r[NCH] |=> pf_flag)
    else $error("power flag not set on power up");

  for (genvar g = 0; g < NCH; g++) begin : g_chk
    grant_src_a: assert property (
      irq_o && irq_sra_o == 6'(g) + `IOPC_SC_FIRST
        |-> $past(flag_r[g] && ctl_r[g] && ien_r))
      else $error("grant to channel without all conditions");
    block_low_a: assert property (req[g] |-> !prio[NCH])
      else $error("chain not broken below requester");
    pass_thru_a: assert property (!flag_r[g] |-> prio[g+1] == prio[g])
      else $error("idle card altered priority");
    set_ctl_a: assert property (x_setc && sel_v[g] |=> dev_start_o[g])
      else $error("set control did not start device");
    clr_ctl_a: assert property (x_clrc && sel_v[g] |=> !ctl_r[g] ##0 !req[g])
      else $error("cleared control still requests");
    flag_clr_a: assert property (
      x_setc && cmd.clr_flag && sel_v[g] && !rise[g] |=> !flag_r[g] && ctl_r[g])
      else $error("set control with clear did not clear flag");
  end

endmodule // iopc_chain

// file: hdl/iopc_map.svh
`ifndef IOPC_MAP_SVH
`define IOPC_MAP_SVH
`define IOPC_ADR_CMD   4'h0
`define IOPC_ADR_ACC   4'h4
`define IOPC_ADR_STAT  4'h8
`define IOPC_SC_IEN    6'h00
`define IOPC_SC_PF     6'h04
`define IOPC_SC_FIRST  6'h08
`define IOPC_NCH       56
`define IOPC_DW        16
`define IOPC_CMD_W     11
`define IOPC_STAT_W    16
`define IOPC_CTL_RST   1'b0
`define IOPC_FLG_RST   1'b0
`define IOPC_IEN_RST   1'b0
`define IOPC_ARM_RST   1'b1
`endif

// file: hdl/iopc_pkg.sv
package iopc_pkg;
  typedef enum logic [3:0] {
    op_set_control   = 4'h0,
    op_clear_control = 4'h1,
    op_set_flag      = 4'h2,
    op_clear_flag    = 4'h3,
    op_skip_set      = 4'h4,
    op_skip_clear    = 4'h5,
    op_load_input    = 4'h6,
    op_merge_input   = 4'h7,
    op_output_acc    = 4'h8
  } iopc_op_t;

  typedef struct packed {
    logic       clr_flag;
    logic [5:0] sc;
    iopc_op_t   op;
  } iopc_cmd_t;

  typedef struct packed {
    logic [5:0] cir;
    logic [5:0] sra;
    logic       irq;
    logic       pf_flag;
    logic       interrupt_system_on;
    logic       skip;
  } iopc_stat_t;
endpackage

// file: verif/iopc_periph.sv
`timescale 1ns/1ps
module iopc_periph #(
  parameter int NCH = 56
) (
  input  wire logic                 clk_i,       // Bench clock
  input  wire logic                 rst_i,       // Synchronous reset
  input  wire logic [NCH-1:0]       dev_start_i, // Start levels
  output logic      [NCH-1:0]       dev_done_o,  // Completion levels
  output logic      [NCH-1:0][15:0] dev_data_o   // Presented data
);
  // Every channel select code has its own card and no slot is empty, so the chain has no gap.
  for (genvar i = 0; i < NCH; i++) begin : g_dev
    // Delays of 8, 14 and 20 cycles give both prompt and slow devices.
    localparam logic [4:0] DLY = 5'(8 + (i % 3) * 6);
    logic [4:0]  cnt_r;
    logic        done_r;
    logic [15:0] dat_r;
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        cnt_r  <= 5'h00;
        done_r <= 1'b0;
        dat_r  <= 16'h0000;
      end else if (!dev_start_i[i]) begin
        cnt_r  <= 5'h00;
        done_r <= 1'b0;
        // An idle device holds nothing, so its data keeps changing.
        dat_r  <= ~dat_r;
      end else if (cnt_r != DLY) begin
        cnt_r <= cnt_r + 5'h01;
        if (cnt_r == DLY - 5'h02) begin
          dat_r <= 16'ha5c0 ^ 16'(i);
        end
      end else begin
        done_r <= 1'b1;
      end
    end
    assign dev_done_o[i] = done_r;
    assign dev_data_o[i] = dat_r;
  end
endmodule // iopc_periph

// file: verif/testbench.sv
`timescale 1ns/1ps
`include "iopc_map.svh"
module testbench;
  localparam int NCH = 56;
  logic                 clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i;
  logic [3:0]           wb_adr_i, wb_sel_i;
  logic [31:0]          wb_dat_i, wb_dat_o, rd;
  logic                 wb_ack_o, pwr_ok_i, int_ack_i, irq_o;
  logic [NCH-1:0]       dev_done_i, dev_start_o;
  logic [NCH-1:0][15:0] dev_data_i, dev_buf_o;
  logic [5:0]           irq_sra_o;
  logic [15:0]          lfsr_r, v, w;
  int                   mismatches, checks_done, ch, a, b, n;

  iopc_chain #(.NCH(NCH)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pwr_ok_i(pwr_ok_i),
    .dev_done_i(dev_done_i), .dev_data_i(dev_data_i), .dev_start_o(dev_start_o),
    .dev_buf_o(dev_buf_o), .int_ack_i(int_ack_i), .irq_o(irq_o), .irq_sra_o(irq_sra_o));
  iopc_periph #(.NCH(NCH)) periph_u (.clk_i(clk_i), .rst_i(rst_i),
    .dev_start_i(dev_start_o), .dev_done_o(dev_done_i), .dev_data_o(dev_data_i));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] rnd();
    lfsr_r = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
    return lfsr_r;
  endfunction
  function automatic logic [5:0] sc_of(input int c);
    return 6'(8 + c);
  endfunction

  task automatic complete_run();
    if (mismatches == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Called just after an edge; returns one edge after the bus went idle.
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat);
    int k;
    k = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    if (wb_ack_o !== 1'b1) begin
      mismatches++;
      complete_run();
    end
    rd = wb_dat_o;
    if (adr == `IOPC_ADR_CMD) chk(irq_o, 0);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic instr(input iopc_pkg::iopc_op_t op, input int c, input logic cf);
    iopc_pkg::iopc_cmd_t cmd;
    cmd.clr_flag = cf;
    cmd.sc = (c < 0) ? 6'(-c - 1) : sc_of(c);
    cmd.op = op;
    wb(1'b1, `IOPC_ADR_CMD, {21'h0, cmd});
    wb(1'b0, `IOPC_ADR_STAT, 32'h0);
  endtask
  task automatic settle();
    repeat (3) @(posedge clk_i);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, int_ack_i} = '0;
    {rst_i, pwr_ok_i, wb_sel_i, lfsr_r} = {1'b1, 1'b1, 4'hf, 16'hd91d};
    mismatches = 0;
    checks_done = 0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    wb(1'b0, `IOPC_ADR_STAT, 32'h0);
    chk(rd, 32'h4);
    wb(1'b0, 4'hc, 32'h0);
    chk(rd, 32'h0);
    // Negative codes address the fixed select codes below the channels.
    pwr_ok_i <= 1'b0;
    settle();
    settle();
    instr(iopc_pkg::op_skip_clear, -5, 1'b0);
    chk(rd[0], 1);
    pwr_ok_i <= 1'b1;
    settle();
    settle();
    instr(iopc_pkg::op_skip_clear, -5, 1'b0);
    chk(rd[0], 0);
    for (int k = 0; k < 4; k++) begin
      ch = int'(rnd()) % NCH;
      v = rnd();
      w = rnd();
      wb(1'b1, `IOPC_ADR_ACC, {16'h0, v});
      instr(iopc_pkg::op_output_acc, ch, 1'b0);
      chk(dev_buf_o[ch], v);
      wb(1'b1, `IOPC_ADR_ACC, {16'h0, w});
      instr(iopc_pkg::op_merge_input, ch, 1'b0);
      wb(1'b0, `IOPC_ADR_ACC, 32'h0);
      chk(rd, {16'h0, v | w});
      instr(iopc_pkg::op_load_input, ch, 1'b0);
      wb(1'b0, `IOPC_ADR_ACC, 32'h0);
      chk(rd, {16'h0, v});
    end
    for (int k = 0; k < 3; k++) begin
      ch = k * 19;
      instr(iopc_pkg::op_set_flag, ch, 1'b0);
      instr(iopc_pkg::op_skip_set, ch, 1'b0);
      chk(rd[0], 1);
      instr(iopc_pkg::op_set_control, ch, 1'b1);
      chk(dev_start_o[ch], 1);
      instr(iopc_pkg::op_skip_clear, ch, 1'b0);
      chk(rd[0], 1);
      n = 0;
      do begin
        instr(iopc_pkg::op_skip_set, ch, 1'b0);
        n++;
      end while (rd[0] !== 1'b1 && n < 20);
      chk(rd[0], 1);
      if (rd[0] !== 1'b1) begin
        complete_run();
      end
      instr(iopc_pkg::op_load_input, ch, 1'b0);
      wb(1'b0, `IOPC_ADR_ACC, 32'h0);
      chk(rd, {16'h0, 16'ha5c0 ^ 16'(ch)});
      instr(iopc_pkg::op_clear_control, ch, 1'b0);
      chk(dev_start_o[ch], 0);
      instr(iopc_pkg::op_clear_flag, ch, 1'b0);
      instr(iopc_pkg::op_skip_clear, ch, 1'b0);
      chk(rd[0], 1);
    end
    instr(iopc_pkg::op_set_control, 2, 1'b1);
    instr(iopc_pkg::op_set_control, 41, 1'b1);
    instr(iopc_pkg::op_clear_control, -1, 1'b0);
    chk({dev_start_o[2], dev_start_o[41]}, 0);
    a = int'(rnd()) % (NCH - 1);
    b = a + 1 + int'(rnd()) % (NCH - 1 - a);
    instr(iopc_pkg::op_set_flag, -1, 1'b0);
    instr(iopc_pkg::op_skip_set, -1, 1'b0);
    chk(rd[0], 1);
    instr(iopc_pkg::op_set_flag, b, 1'b0);
    instr(iopc_pkg::op_set_control, b, 1'b0);
    settle();
    chk({irq_o, irq_sra_o}, {1'b1, sc_of(b)});
    instr(iopc_pkg::op_set_control, a, 1'b0);
    settle();
    chk(irq_sra_o, sc_of(b));
    instr(iopc_pkg::op_set_flag, a, 1'b0);
    settle();
    chk(irq_sra_o, sc_of(a));
    int_ack_i <= 1'b1;
    @(posedge clk_i);
    int_ack_i <= 1'b0;
    instr(iopc_pkg::op_load_input, -5, 1'b0);
    wb(1'b0, `IOPC_ADR_ACC, 32'h0);
    chk(rd, {26'h0, sc_of(a)});
    instr(iopc_pkg::op_clear_flag, -1, 1'b0);
    settle();
    chk(irq_o, 0);
    instr(iopc_pkg::op_set_flag, -1, 1'b0);
    instr(iopc_pkg::op_clear_control, a, 1'b0);
    settle();
    chk({irq_o, irq_sra_o}, {1'b1, sc_of(b)});
    instr(iopc_pkg::op_skip_set, a, 1'b0);
    chk(rd[0], 1);
    instr(iopc_pkg::op_clear_flag, b, 1'b0);
    settle();
    chk(irq_o, 0);
    instr(iopc_pkg::op_set_control, a, 1'b0);
    settle();
    chk({irq_o, irq_sra_o}, {1'b1, sc_of(a)});
    // A power failure must overtake a channel that is already requesting.
    pwr_ok_i <= 1'b0;
    settle();
    settle();
    chk({irq_o, irq_sra_o}, {1'b1, `IOPC_SC_PF});
    int_ack_i <= 1'b1;
    @(posedge clk_i);
    int_ack_i <= 1'b0;
    settle();
    chk({irq_o, irq_sra_o}, {1'b1, sc_of(a)});
    instr(iopc_pkg::op_load_input, -5, 1'b0);
    wb(1'b0, `IOPC_ADR_ACC, 32'h0);
    chk(rd, {26'h0, `IOPC_SC_PF});
    instr(iopc_pkg::op_load_input, -1, 1'b0);
    wb(1'b0, `IOPC_ADR_ACC, 32'h0);
    chk(rd, 32'h0);
    complete_run();
  end
endmodule // testbench
